// *** verilog/serial_channel_consts.vh ***
/*
 * Register offsets, field positions, reset values and bit timing of one
 * serial channel. Assumes a 12-bit APB byte address; every register is one
 * aligned 32-bit word with its data in the low byte.
 */
`ifndef SERIAL_CHANNEL_CONSTS_VH
`define SERIAL_CHANNEL_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SC_OFS_FMT    12'h000
`define SC_OFS_DIV    12'h004
`define SC_OFS_CTRL   12'h008
`define SC_OFS_TXH    12'h00C
`define SC_OFS_STAT   12'h010
`define SC_OFS_RXH    12'h014

// ----------------------------------------------------------------------
// Frame format fields
// ----------------------------------------------------------------------
`define SC_FMT_SYNC   7
`define SC_FMT_LEN7   6
`define SC_FMT_PAR    5
`define SC_FMT_ODD    4
`define SC_FMT_STOP2  3
`define SC_FMT_MULT   2
`define SC_FMT_CKSHI  1
`define SC_FMT_CKSLO  0

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define SC_CTRL_TXEN  0
`define SC_CTRL_RXEN  1
`define SC_CTRL_CARD  2
`define SC_CTRL_MPBT  3

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define SC_ST_TXE     0
`define SC_ST_RXF     1
`define SC_ST_PER     2
`define SC_ST_ORER    3
`define SC_ST_FER     4
`define SC_ST_PIN     5
`define SC_ST_TEND    6
`define SC_ST_MPB     7

// ----------------------------------------------------------------------
// Reset values and bit timing (16 ticks per bit)
// ----------------------------------------------------------------------
`define SC_FMT_RST    8'h00
`define SC_DIV_RST    8'hFF
`define SC_CTRL_RST   8'h00
`define SC_TICK_LAST  4'hF
`define SC_TICK_MID   4'h7
`define SC_ERR_PHASE  4'h8

`endif

// *** verilog/baud_tick_gen.v ***
/*
 * Baud tick generator: prescaler of 1, 4, 16 or 64 followed by a
 * divide-by-(divisor+1) counter. Gives a one-cycle enable at 16x bit rate.
 * Assumes settings change only while the channel is idle.
 */
`timescale 1ns/10ps

module baud_tick_gen (
   // Clock and reset
   input  wire       clk_sys,
   input  wire       reset,
   // Settings
   input  wire [1:0] prescaleSel,
   input  wire [7:0] divisor,
   // Enable out
   output reg        tick
);

   reg  [5:0] preCnt_q;
   reg  [7:0] divCnt_q;
   reg        preEn;

   always @* begin
      case (prescaleSel)
         2'h0:    preEn = 1'b1;
         2'h1:    preEn = (preCnt_q[1:0] == 2'h3);
         2'h2:    preEn = (preCnt_q[3:0] == 4'hF);
         default: preEn = (preCnt_q == 6'h3F);
      endcase
   end

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         preCnt_q <= 6'h00;
         divCnt_q <= 8'h00;
         tick     <= 1'b0;
      end else begin
         preCnt_q <= preCnt_q + 6'h01;
         tick     <= 1'b0;
         if (preEn) begin
            if (divCnt_q >= divisor) begin
               divCnt_q <= 8'h00;
               tick     <= 1'b1;
            end else begin
               divCnt_q <= divCnt_q + 8'h01;
            end
         end
      end
   end

endmodule // baud_tick_gen

// *** verilog/serial_async_sync_channel.v ***
/*
 * One serial channel: asynchronous and clocked synchronous framing, double
 * buffered receiver and transmitter, frame format register, APB slave.
 * Assumes rxd is asynchronous to clk_sys; the far end honours framing.
 */
// Overview of operation
// - Shift in bits, copy byte to holding.
// - Receive holding is 8 bits, read only.
// - Receive shifter free right after transfer.
// - Empty transmit shifter loads holding, starts sending.
// - Waiting byte loads without gap between characters.
// - Shift registers not reachable from the bus.
// - Format bit 7 selects async or synchronous.
// - Format bit 6 selects 7 or 8 bits.
// - Synchronous mode always uses 8-bit characters.
// - Format bit 5 adds and checks parity.
// - Multiprocessor format disables parity entirely.
// - Format bit 4 selects even or odd.
// - Format bit 3 selects one or two stops.
// - Receiver checks only the first stop bit.
// - Low after first stop starts next character.
// - Async receive flags parity, overrun, framing errors.
// - Synchronous receive flags only overrun errors.
// - Receive pin level readable by software.
// - Card mode receiver drives error on parity.
// - Card mode transmitter retransmits on error signal.
// - Format bits 1:0 pick prescale 1/4/16/64.
// - Format bit 2 enables multiprocessor format.
`timescale 1ns/10ps
`include "serial_channel_consts.vh"

module serial_async_sync_channel (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        reset,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Serial pins
   input  wire        rxd,
   output reg         txd,
   output reg         sckOut,
   output reg         sckOe
);

   // ----------------------------------------------------------------------
   // States
   // ----------------------------------------------------------------------
   localparam [2:0] T_IDLE  = 3'h0;
   localparam [2:0] T_START = 3'h1;
   localparam [2:0] T_DATA  = 3'h2;
   localparam [2:0] T_PAR   = 3'h3;
   localparam [2:0] T_STOP  = 3'h4;
   localparam [2:0] T_GUARD = 3'h5;

   localparam [2:0] R_IDLE  = 3'h0;
   localparam [2:0] R_START = 3'h1;
   localparam [2:0] R_DATA  = 3'h2;
   localparam [2:0] R_PAR   = 3'h3;
   localparam [2:0] R_STOP  = 3'h4;
   localparam [2:0] R_ERR   = 3'h5;

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   reg  [7:0] fmt_q;
   reg  [7:0] divisor_q;
   reg  [7:0] ctrl_q;
   reg  [7:0] txHold_q;
   reg        txFull_q;
   reg  [7:0] rxHold_q;
   reg        rxFull_q;
   reg        parErr_q;
   reg        overrun_q;
   reg        framing_q;
   reg        mpbRx_q;
   reg        rxMeta_q;
   reg        rxPin_q;
   reg  [2:0] txState_q;
   reg  [3:0] txTick_q;
   reg  [3:0] txBit_q;
   reg  [7:0] txShift_q;
   reg  [7:0] txByte_q;
   reg        guardErr_q;
   reg  [2:0] rxState_q;
   reg  [3:0] rxTick_q;
   reg  [3:0] rxBit_q;
   reg  [7:0] rxShift_q;
   reg        rxParBit_q;
   reg        errDrive_q;
   reg        txLevel;
   reg  [7:0] rdMux;
   reg        rdHit;
   wire       tick;

   // ----------------------------------------------------------------------
   // Format decode
   // ----------------------------------------------------------------------
   wire       syncMode = fmt_q[`SC_FMT_SYNC];
   wire       cardMode = ctrl_q[`SC_CTRL_CARD];
   wire       sevenBit  = ~syncMode & ~cardMode & fmt_q[`SC_FMT_LEN7];
   wire       multiMode = ~syncMode & ~cardMode & fmt_q[`SC_FMT_MULT];
   wire       parOn     = ~syncMode & ~multiMode & (fmt_q[`SC_FMT_PAR] | cardMode);
   wire       oddPar   = fmt_q[`SC_FMT_ODD];
   wire       twoStop  = fmt_q[`SC_FMT_STOP2];
   wire       txEn     = ctrl_q[`SC_CTRL_TXEN];
   wire       rxEn     = ctrl_q[`SC_CTRL_RXEN];
   wire [3:0] lastBit  = sevenBit ? 4'h6 : 4'h7;

   // ----------------------------------------------------------------------
   // APB access decode
   // ----------------------------------------------------------------------
   wire       apbDone  = psel & penable & pready;
   wire       apbWr    = apbDone & pwrite;
   wire       rxRead   = apbDone & ~pwrite & (paddr == `SC_OFS_RXH);
   wire       txWrite  = apbWr & (paddr == `SC_OFS_TXH);
   wire       statWr   = apbWr & (paddr == `SC_OFS_STAT);
   wire       txEnd    = (txState_q == T_IDLE) & ~txFull_q;

   // ----------------------------------------------------------------------
   // Baud ticks
   // ----------------------------------------------------------------------
   baud_tick_gen u_baud (
      .clk_sys     (clk_sys),
      .reset       (reset),
      .prescaleSel (fmt_q[`SC_FMT_CKSHI:`SC_FMT_CKSLO]),
      .divisor     (divisor_q),
      .tick        (tick)
   );

   // ----------------------------------------------------------------------
   // Receive pin synchroniser
   // ----------------------------------------------------------------------
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rxMeta_q <= 1'b1;
         rxPin_q  <= 1'b1;
      end else begin
         rxMeta_q <= rxd;
         rxPin_q  <= rxMeta_q;
      end
   end

   // ----------------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------------
   wire txBitEnd   = tick & (txTick_q == `SC_TICK_LAST);
   wire txParity   = ^(txByte_q & (sevenBit ? 8'h7F : 8'hFF)) ^ oddPar;
   wire txFrameEnd = txBitEnd & (
                     ((txState_q == T_DATA) & syncMode & (txBit_q == 4'h7)) |
                     ((txState_q == T_STOP) & ~cardMode & (~twoStop | txBit_q[0])) |
                     ((txState_q == T_GUARD) & ~guardErr_q));
   wire txRetry    = txBitEnd & (txState_q == T_GUARD) & guardErr_q;
   // Next byte goes straight in as the frame ends, so no idle bit appears
   wire txLoad     = txEn & txFull_q & ((txState_q == T_IDLE) | txFrameEnd);

   always @* begin
      case (txState_q)
         T_START: txLevel = 1'b0;
         T_DATA:  txLevel = txShift_q[0];
         T_PAR:   txLevel = multiMode ? ctrl_q[`SC_CTRL_MPBT] : txParity;
         default: txLevel = 1'b1;
      endcase
   end

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         txState_q  <= T_IDLE;
         txTick_q   <= 4'h0;
         txBit_q    <= 4'h0;
         txShift_q  <= 8'h00;
         txByte_q   <= 8'h00;
         guardErr_q <= 1'b0;
      end else begin
         if (tick) begin
            txTick_q <= txTick_q + 4'h1;
         end
         if (txLoad | txRetry) begin
            txShift_q  <= txLoad ? txHold_q : txByte_q;
            txTick_q   <= 4'h0;
            txBit_q    <= 4'h0;
            guardErr_q <= 1'b0;
            txState_q  <= syncMode ? T_DATA : T_START;
            if (txLoad) begin
               txByte_q <= txHold_q;
            end
         end else if (txFrameEnd) begin
            txState_q <= T_IDLE;
         end else if (txBitEnd) begin
            case (txState_q)
               T_START: begin
                  txState_q <= T_DATA;
               end
               T_DATA: begin
                  txShift_q <= {1'b0, txShift_q[7:1]};
                  txBit_q   <= txBit_q + 4'h1;
                  if (txBit_q == lastBit) begin
                     txBit_q   <= 4'h0;
                     txState_q <= (parOn | multiMode) ? T_PAR : T_STOP;
                  end
               end
               T_PAR: begin
                  txState_q <= T_STOP;
               end
               T_STOP: begin
                  if (cardMode) begin
                     txState_q <= T_GUARD;
                  end else begin
                     txBit_q <= 4'h1;
                  end
               end
               default: begin
                  txState_q <= T_IDLE;
               end
            endcase
         end
         // Error signal from the card is sampled mid guard bit
         if ((txState_q == T_GUARD) & tick & (txTick_q == `SC_TICK_MID) & ~rxPin_q) begin
            guardErr_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Receiver
   // ----------------------------------------------------------------------
   wire       rxSamp     = tick & (rxTick_q == `SC_TICK_LAST);
   // Synchronous data is sampled just before our own clock rises
   wire       syncStrobe = syncMode & (txState_q == T_DATA) & tick & (txTick_q == `SC_TICK_MID);
   wire       asyncDone  = (rxState_q == R_STOP) & rxSamp;
   wire       syncDone   = rxEn & syncStrobe & (rxBit_q == 4'h7) & (rxState_q == R_IDLE);
   wire       rxDone     = asyncDone | syncDone;
   wire [7:0] rxWord     = syncMode ? {rxPin_q, rxShift_q[7:1]} :
                           (sevenBit ? {1'b0, rxShift_q[7:1]} : rxShift_q);
   wire       parBad     = parOn & (^rxWord ^ rxParBit_q ^ oddPar);

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rxState_q  <= R_IDLE;
         rxTick_q   <= 4'h0;
         rxBit_q    <= 4'h0;
         rxShift_q  <= 8'h00;
         rxParBit_q <= 1'b0;
         errDrive_q <= 1'b0;
      end else begin
         if (tick) begin
            rxTick_q <= rxTick_q + 4'h1;
         end
         errDrive_q <= (rxState_q == R_ERR) & rxBit_q[0];
         case (rxState_q)
            R_IDLE: begin
               if (rxEn & ~syncMode & ~rxPin_q) begin
                  rxState_q <= R_START;
                  rxTick_q  <= 4'h0;
               end
               if (~syncMode | ~rxEn) begin
                  rxBit_q <= 4'h0;
               end else if (syncStrobe) begin
                  rxShift_q <= {rxPin_q, rxShift_q[7:1]};
                  rxBit_q   <= (rxBit_q == 4'h7) ? 4'h0 : rxBit_q + 4'h1;
               end
            end
            R_START: begin
               if (tick & (rxTick_q == `SC_TICK_MID)) begin
                  // A start bit gone by mid bit was a glitch
                  rxState_q <= rxPin_q ? R_IDLE : R_DATA;
                  rxTick_q  <= 4'h0;
                  rxBit_q   <= 4'h0;
               end
            end
            R_DATA: begin
               if (rxSamp) begin
                  rxShift_q <= {rxPin_q, rxShift_q[7:1]};
                  rxBit_q   <= rxBit_q + 4'h1;
                  if (rxBit_q == lastBit) begin
                     rxState_q <= (parOn | multiMode) ? R_PAR : R_STOP;
                  end
               end
            end
            R_PAR: begin
               if (rxSamp) begin
                  rxParBit_q <= rxPin_q;
                  rxState_q  <= R_STOP;
               end
            end
            R_STOP: begin
               if (rxSamp) begin
                  // Only the first stop is looked at; idle hunts for next start
                  rxState_q <= (cardMode & parBad) ? R_ERR : R_IDLE;
                  rxTick_q  <= `SC_ERR_PHASE;
                  rxBit_q   <= 4'h0;
               end
            end
            R_ERR: begin
               if (rxSamp) begin
                  rxBit_q <= 4'h1;
                  if (rxBit_q[0]) begin
                     rxState_q <= R_IDLE;
                  end
               end
            end
            default: begin
               rxState_q <= R_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Registers and flags
   // ----------------------------------------------------------------------
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fmt_q     <= `SC_FMT_RST;
         divisor_q <= `SC_DIV_RST;
         ctrl_q    <= `SC_CTRL_RST;
         txHold_q  <= 8'h00;
         txFull_q  <= 1'b0;
         rxHold_q  <= 8'h00;
         rxFull_q  <= 1'b0;
         parErr_q  <= 1'b0;
         overrun_q <= 1'b0;
         framing_q <= 1'b0;
         mpbRx_q   <= 1'b0;
      end else begin
         if (apbWr & (paddr == `SC_OFS_FMT)) begin
            fmt_q <= pwdata[7:0];
         end
         if (apbWr & (paddr == `SC_OFS_DIV)) begin
            divisor_q <= pwdata[7:0];
         end
         if (apbWr & (paddr == `SC_OFS_CTRL)) begin
            ctrl_q <= {4'h0, pwdata[3:0]};
         end
         // A write always refills; it wins over the shifter's load
         if (txWrite) begin
            txHold_q <= pwdata[7:0];
            txFull_q <= 1'b1;
         end else if (txLoad) begin
            txFull_q <= 1'b0;
         end
         if (statWr) begin
            parErr_q  <= parErr_q & ~pwdata[`SC_ST_PER];
            overrun_q <= overrun_q & ~pwdata[`SC_ST_ORER];
            framing_q <= framing_q & ~pwdata[`SC_ST_FER];
         end
         if (rxRead) begin
            rxFull_q <= 1'b0;
         end
         if (rxDone) begin
            if (rxFull_q & ~rxRead) begin
               overrun_q <= 1'b1;
            end else begin
               rxHold_q <= rxWord;
               rxFull_q <= 1'b1;
               mpbRx_q  <= multiMode & rxParBit_q;
            end
         end
         if (asyncDone & ~rxPin_q) begin
            framing_q <= 1'b1;
         end
         if (asyncDone & parBad) begin
            parErr_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // APB read mux; shifters have no address
   // ----------------------------------------------------------------------
   always @* begin
      rdHit = 1'b1;
      case (paddr)
         `SC_OFS_FMT:  rdMux = fmt_q;
         `SC_OFS_DIV:  rdMux = divisor_q;
         `SC_OFS_CTRL: rdMux = ctrl_q;
         `SC_OFS_TXH:  rdMux = txHold_q;
         `SC_OFS_STAT: rdMux = {mpbRx_q, txEnd, rxPin_q, framing_q,
                                overrun_q, parErr_q, rxFull_q, ~txFull_q};
         `SC_OFS_RXH:  rdMux = rxHold_q;
         default: begin
            rdMux = 8'h00;
            rdHit = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Bus and pin outputs, all registered
   // ----------------------------------------------------------------------
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         txd     <= 1'b1;
         sckOut  <= 1'b1;
         sckOe   <= 1'b0;
      end else begin
         // One wait state: answer comes in the second access cycle
         pready <= psel & penable & ~pready;
         if (psel & penable & ~pready) begin
            prdata  <= {24'h00_0000, rdMux};
            pslverr <= ~rdHit;
         end
         txd    <= txLevel & ~errDrive_q;
         sckOut <= ~(syncMode & (txState_q == T_DATA)) | txTick_q[3];
         sckOe  <= syncMode;
      end
   end

endmodule // serial_async_sync_channel

// *** testbench/serial_channel_monitor.sv ***
/* Port-level checks of the serial channel: APB timing, format register, pins.
   Assumes a master that holds each request until pready. */
`timescale 1ns/10ps
module serial_channel_monitor (
   // Clock and reset
   input wire        clk_sys,
   input wire        reset,
   // APB
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // Serial pins
   input wire        rxd,
   input wire        txd,
   input wire        sckOut,
   input wire        sckOe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   reg  [7:0] fmtShadow_q;
   wire       done  = psel && penable && pready;
   wire       fmtWr = done && pwrite && paddr == 12'h000;
   always @(posedge clk_sys or posedge reset) begin
      if (reset) fmtShadow_q <= 8'h00;
      else if (fmtWr) fmtShadow_q <= pwdata[7:0];
   end
   pready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
   wait_state_a: assert property (psel && !penable |=> !pready ##1 pready) else $error("wrong wait states");
   upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000) else $error("upper read bits set");
   fmt_read_a: assert property (done && !pwrite && paddr == 12'h000 |-> prdata[7:0] == fmtShadow_q)
      else $error("format readback wrong");
   mode_pin_a: assert property (fmtWr |-> ##2 sckOe == fmtShadow_q[7]) else $error("mode pin wrong");
   unmapped_err_a: assert property (pready && !pwrite && paddr > 12'h017 |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   mapped_ok_a: assert property (pready && paddr <= 12'h014 && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped access refused");
   start_bit_a: assert property ($fell(txd) && !sckOe |-> !txd [*8]) else $error("start bit too short");
   sck_idle_a: assert property (!sckOe |-> sckOut) else $error("clock pin not idle high");
   idle_out_a: assert property ($fell(reset) |-> txd && !pready) else $error("bad idle after reset");
   cover property (done && pslverr);
   cover property ($fell(txd));
   cover property ($rose(sckOe));
endmodule // serial_channel_monitor

bind serial_async_sync_channel serial_channel_monitor mon (.clk_sys(clk_sys), .reset(reset), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rxd(rxd), .txd(txd), .sckOut(sckOut), .sckOe(sckOe));

// *** testbench/serial_peer_model.sv ***
/* Remote asynchronous transceiver: sends frames on rxd, decodes txd frames.
   Assumes the bench sets bit length and format before traffic. */
`timescale 1ns/10ps
module serial_peer_model (
   // Clock
   input  wire  clk_sys,
   // Serial lines
   input  wire  txd,
   output logic rxd
);
   int         nb = 8;
   int         bt = 16;
   bit         parEn;
   bit         st2;
   logic [9:0] got[$];
   initial rxd = 1'b1; // Line idles high
   task automatic bitOut(input logic b);
      rxd <= b;
      repeat (bt) @(posedge clk_sys);
   endtask
   // Start low, data LSB first, optional parity, stop
   task automatic send(input logic [7:0] d, input logic p, input logic stp);
      bitOut(1'b0);
      for (int i = 0; i < nb; i++) bitOut(d[i]);
      if (parEn) bitOut(p);
      bitOut(stp);
   endtask
   // Samples mid-bit; second stop only checked when two are expected
   always begin : decode
      logic [9:0] f;
      @(negedge txd);
      f = 10'h300;
      repeat (bt / 2) @(posedge clk_sys);
      for (int i = 0; i < nb; i++) begin
         repeat (bt) @(posedge clk_sys);
         f[i] = txd;
      end
      if (parEn) begin
         repeat (bt) @(posedge clk_sys);
         f[8] = txd;
      end
      // Stop is the last bit looked at, so a back-to-back start is not eaten
      repeat (bt) @(posedge clk_sys);
      f[9] = txd;
      if (st2) begin
         repeat (bt) @(posedge clk_sys);
         f[9] = f[9] & txd;
      end
      got.push_back(f);
   end
endmodule // serial_peer_model

// *** testbench/tb_serial_async_sync_channel.sv ***
/* Self-checking bench of the serial channel over APB and the serial pins.
   Assumes the peer model on the pins and 16 clocks per bit at divisor 0. */
`timescale 1ns/10ps
`include "serial_channel_consts.vh"
module tb_serial_async_sync_channel;
   localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
   logic        clk_sys = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, rdv;
   wire  [31:0] prdata;
   wire         pready, pslverr, rxd, txd, sckOut, sckOe;
   logic [32:0] expQ[$], mskQ[$], e, m;
   logic [9:0]  txQ[$];
   logic [7:0]  cfg[8] = '{8'h00, 8'h40, 8'h20, 8'h70, 8'h08, 8'h24, 8'h01, 8'h02};
   logic [7:0]  f, d, e2, pm;
   int          num_errors = 0, compares = 0;
   serial_async_sync_channel dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rxd(rxd), .txd(txd), .sckOut(sckOut), .sckOe(sckOe));
   serial_peer_model peer (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));
   always #2 clk_sys = ~clk_sys;
   task automatic chk(input logic [32:0] g, input logic [32:0] x);
      compares++;
      if (g !== x) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic give_verdict;
      if (num_errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   function automatic logic par(input logic [7:0] v, input logic odd);
      return ^v ^ odd;
   endfunction
   // ----------------------------------------------------------------------
   // APB master and result watchers
   // ----------------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] x,
                      input logic [32:0] k);
      expQ.push_back(x);
      mskQ.push_back(k);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rdv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd, 33'h0, 33'h1_0000_0000);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] x, input logic [32:0] k);
      apb(1'b0, a, 32'h0, x, k);
   endtask
   task automatic waitSt(input int b);
      do rd(`SC_OFS_STAT, 33'h0, 33'h0); while (rdv[b] !== 1'b1);
   endtask
   always @(posedge clk_sys) begin
      if (psel && penable && pready === 1'b1) begin
         e = expQ.pop_front();
         m = mskQ.pop_front();
         if (m != 0) chk({pslverr, prdata} & m, e & m);
      end
      if (peer.got.size() > 0) chk(peer.got.pop_front(), txQ.pop_front());
   end
   initial begin
      #400_000;
      num_errors++;
      give_verdict;
   end
   initial begin
      void'($urandom(32'h0000_e8d9));
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      rd(`SC_OFS_FMT, 33'h0, ALL);
      wr(`SC_OFS_RXH, 32'h0000_00A5);
      rd(`SC_OFS_RXH, 33'h0, ALL);
      apb(1'b1, 12'h040, 32'h0000_0001, 33'h1_0000_0000, 33'h1_0000_0000);
      rd(12'h020, 33'h1_0000_0000, ALL);
      wr(`SC_OFS_DIV, 32'h0);
      wr(`SC_OFS_CTRL, 32'h0000_0003);
      foreach (cfg[i]) begin
         f = cfg[i];
         pm = f[6] ? 8'h7F : 8'hFF;
         peer.nb = f[6] ? 7 : 8;
         peer.parEn = f[5] | f[2];
         peer.st2 = f[3];
         peer.bt = 16 << (2 * f[1:0]);
         wr(`SC_OFS_FMT, {24'h00_0000, f});
         repeat (2) begin
            d = $urandom;
            txQ.push_back({1'b1, !peer.parEn | (!f[2] & par(d & pm, f[4])), d & pm});
            waitSt(`SC_ST_TXE);
            wr(`SC_OFS_TXH, {24'h00_0000, d});
         end
         d = $urandom;
         peer.send(d, f[2] ^ par(d & pm, f[4]), 1'b1);
         waitSt(`SC_ST_RXF);
         rd(`SC_OFS_RXH, {25'h0, d & pm}, {25'h1FF_FFFF, pm});
         rd(`SC_OFS_STAT, 33'h0, 33'h1C);
         waitSt(`SC_ST_TEND);
      end
      wr(`SC_OFS_FMT, 32'h0000_0020);
      peer.parEn = 1;
      peer.bt = 16;
      d = $urandom;
      peer.send(d, ~par(d, 1'b0), 1'b0);
      waitSt(`SC_ST_RXF);
      rd(`SC_OFS_STAT, 33'h14, 33'h1C);
      rd(`SC_OFS_RXH, {25'h0, d}, ALL);
      rd(`SC_OFS_STAT, 33'h0, 33'h20);
      repeat (12) peer.bitOut(1'b1);
      wr(`SC_OFS_STAT, 32'h0000_001C);
      rd(`SC_OFS_RXH, 33'h0, 33'h0);
      wr(`SC_OFS_FMT, 32'h0000_0008);
      peer.parEn = 0;
      d = $urandom;
      e2 = $urandom;
      fork
         begin
            peer.send(d, 1'b0, 1'b1);
            peer.send(e2, 1'b0, 1'b1);
            peer.send(~d, 1'b0, 1'b1);
         end
         begin
            waitSt(`SC_ST_RXF);
            rd(`SC_OFS_RXH, {25'h0, d}, ALL);
         end
      join
      rd(`SC_OFS_STAT, 33'h0A, 33'h0A);
      rd(`SC_OFS_RXH, {25'h0, e2}, ALL);
      wr(`SC_OFS_FMT, 32'h0000_00C0);
      rd(`SC_OFS_FMT, 33'hC0, ALL);
      // All-ones byte keeps txd high, so the peer sees no start bit
      wr(`SC_OFS_TXH, 32'h0000_00FF);
      waitSt(`SC_ST_RXF);
      rd(`SC_OFS_RXH, 33'hFF, ALL);
      repeat (4) @(posedge clk_sys);
      give_verdict;
   end
endmodule // tb_serial_async_sync_channel
